// File: logic/sdl_defs.vh
// constants shared by the six-channel decimating loader files
`ifndef SDL_DEFS_VH
`define SDL_DEFS_VH

// pixel code width and full-scale code
`define SDL_CODE_W      10
`define SDL_CODE_FULL   10'h3FF
`define SDL_CODE_RST    10'h000

// channel count and pointer layout
`define SDL_NCH         6
`define SDL_PTR_W       3
`define SDL_CH_LEFT     3'h0
`define SDL_CH_RIGHT    3'h5
`define SDL_LOADS_LAST  3'h5

// loader state codes
`define SDL_ST_IDLE     1'b0
`define SDL_ST_LOAD     1'b1

// clock period in ns, for reference by timing figures
`define SDL_CLK_NS      10

`endif

// File: logic/sdl_chan_conv.v
// one output converter channel: holds the transferred code and its drive figures
`timescale 1ns/10ps
`default_nettype none
`include "sdl_defs.vh"

module sdl_chan_conv (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    ce,
  input  wire                    xfer,
  input  wire [`SDL_CODE_W-1:0]  code_in,
  input  wire                    polarity_invert,
  input  wire                    low_power_hold,
  output reg  [`SDL_CODE_W-1:0]  code_q,
  output reg  [`SDL_CODE_W-1:0]  away_steps_q,
  output reg                     above_mid_q,
  output reg                     drive_en_q
);

  // steps away from the reference level: full-scale code gives zero
  function [`SDL_CODE_W-1:0] away_of;
    input [`SDL_CODE_W-1:0] c;
    begin
      away_of = `SDL_CODE_FULL - c;
    end
  endfunction

  // code and step count change only on a transfer, so all six move together
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q       <= `SDL_CODE_RST;
      away_steps_q <= `SDL_CODE_FULL;
      above_mid_q  <= 1'b0;
      drive_en_q   <= 1'b0;
    end else if (ce) begin
      if (xfer) begin
        code_q       <= code_in;
        away_steps_q <= away_of(code_in);  // [R11]
      end
      above_mid_q <= polarity_invert;      // [R9]
      drive_en_q  <= ~low_power_hold;      // [R10]
    end
  end

endmodule // sdl_chan_conv

`default_nettype wire

// File: logic/sdl_loader.v
// six-channel decimating loader: edge-selected code loading, transfer, output drive
// Behaviour
// R1: each load captures the whole 10-bit code
// R2: sequence start sampled only on active edge
// R3: sequence begins on the next active edge
// R4: edge select high rising, low falling
// R5: one code captured per active edge
// R6: direction low starts channel 0, high 5
// R7: transfer strobe detected on rising edges only
// R8: next rising edge moves all six codes out
// R9: polarity input selects region above or below midpoint
// R10: hold input debiases the channel drivers
// R11: output steps away linearly from code 1023
// R12: pointer walks six channels then stops
// R13: controller strobes transfer after six loads
`timescale 1ns/10ps
`default_nettype none
`include "sdl_defs.vh"

module sdl_loader (
  // clock, reset and enable
  input  wire                          clk,
  input  wire                          arst_n,
  input  wire                          ce,
  // controller side: codes, strobes and selects
  input  wire [`SDL_CODE_W-1:0]        pixel_code_in,
  input  wire                          load_sequence_start,
  input  wire                          scan_direction_select,
  input  wire                          edge_phase_select,
  input  wire                          output_transfer_strobe,
  input  wire                          polarity_invert,
  input  wire                          low_power_hold,
  // converter side
  output wire [`SDL_CODE_W*`SDL_NCH-1:0] channel_outputs,
  output wire [`SDL_CODE_W*`SDL_NCH-1:0] channel_away_steps,
  output wire [`SDL_NCH-1:0]           channel_above_mid,
  output wire [`SDL_NCH-1:0]           channel_drive_en,
  // walk status, kept visible for observation
  output reg                           load_busy_q,
  output reg  [`SDL_PTR_W-1:0]         load_ptr_q,
  output reg                           xfer_pending_q
);

  // timing at a glance, counted in rising edges of clk:
  //   edge N     start seen, walk armed, pointer set to the first channel
  //   edge N+1   first code latched at the starting channel
  //   edge N+6   sixth code latched; busy drops after this edge
  //   edge T     transfer strobe seen, pending flag rises
  //   edge T+1   all six converters take the latches at once
  // in falling-edge mode the start and code values are those sampled half
  // a cycle before each rising edge, so the same counts hold in both modes
  // a start on a loading edge restarts the walk and that edge loads nothing
  // ce low freezes every register, the half-cycle capture included, but
  // not the reset synchroniser: reset release is never held off by ce
  // there is no guard against a transfer in mid-walk; the converters then
  // show a mix of old and new codes until the next complete transfer

  localparam ST_IDLE = `SDL_ST_IDLE;
  localparam ST_LOAD = `SDL_ST_LOAD;

  // reset release through two flops; assertion stays asynchronous
  // so that every register leaves reset on the same edge; a release that
  // landed near an edge would otherwise free some flops a cycle early
  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // falling-edge capture of code and start; the controller shares our clock,
  // so no synchroniser is needed, only a half-cycle register
  // both samples run whatever the phase select says, so switching modes
  // between walks needs no settling time
  reg [`SDL_CODE_W-1:0] fall_code_q;
  reg                   fall_start_q;

  always @(negedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fall_code_q  <= `SDL_CODE_RST;
      fall_start_q <= 1'b0;
    end else if (ce) begin
      fall_code_q  <= pixel_code_in;        // [R5]
      fall_start_q <= load_sequence_start;  // [R2]
    end
  end

  // pick the sample of the active edge; one active edge per clock period
  // either way, so the loader itself runs on the rising edge
  // trade-off: falling-edge mode adds half a cycle of input setup but
  // keeps one clock domain for the whole loader
  wire [`SDL_CODE_W-1:0] act_code;
  wire                   act_start;

  assign act_code  = edge_phase_select ? pixel_code_in : fall_code_q;         // [R4]
  assign act_start = edge_phase_select ? load_sequence_start : fall_start_q; // [R2]

  // next channel in the scan direction; the walk stops after six codes,
  // so the pointer never steps past either end
  function [`SDL_PTR_W-1:0] step_ptr;
    input [`SDL_PTR_W-1:0] p;
    input                  right_to_left;
    begin
      if (right_to_left)
        step_ptr = p - 3'h1;
      else
        step_ptr = p + 3'h1;
    end
  endfunction

  // starting channel of a sequence
  function [`SDL_PTR_W-1:0] first_ptr;
    input right_to_left;
    begin
      first_ptr = right_to_left ? `SDL_CH_RIGHT : `SDL_CH_LEFT;
    end
  endfunction

  // loader state; cnt_q counts codes already taken in this walk and
  // dir_q keeps the direction seen on the start edge
  reg                   state_q;
  reg                   state_d;
  reg                   dir_q;
  reg                   dir_d;
  reg [`SDL_PTR_W-1:0]  ptr_d;
  reg [`SDL_PTR_W-1:0]  cnt_q;
  reg [`SDL_PTR_W-1:0]  cnt_d;
  reg                   arm_q;
  reg                   arm_d;
  reg                   wr_en;

  // channel latches, addressed by the pointer
  reg [`SDL_CODE_W-1:0] lat_q [0:`SDL_NCH-1];
  integer i;

  // the sixth load of a walk; the loader drops back to idle after it
  wire walk_last;

  assign walk_last = (state_q == ST_LOAD) && (cnt_q == `SDL_LOADS_LAST);

  // idle holds the pointer until a start arms the loader; load writes one
  // latch per edge and counts to six. the start override sits last so that
  // it wins over whatever the state would do on the same edge
  // next-state: a start seen on one active edge arms the loader, and the
  // first code goes in on the following active edge; a new start restarts
  // the walk even in the middle of a sequence
  always @* begin
    state_d = state_q;
    dir_d   = dir_q;
    ptr_d   = load_ptr_q;
    cnt_d   = cnt_q;
    arm_d   = 1'b0;
    wr_en   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (arm_q) begin
          state_d = ST_LOAD;
          wr_en   = 1'b1;                        // [R3]
          cnt_d   = 3'h1;
          ptr_d   = step_ptr(load_ptr_q, dir_q); // [R12]
        end
      end
      ST_LOAD: begin
        wr_en = 1'b1;                            // [R5]
        if (walk_last) begin
          state_d = ST_IDLE;                     // [R12]
          cnt_d   = 3'h0;
        end else begin
          cnt_d = cnt_q + 3'h1;
          ptr_d = step_ptr(load_ptr_q, dir_q);   // [R12]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (arm_q && state_q == ST_LOAD) begin
      // arm_q with ST_LOAD cannot arise, as a start always sets ST_IDLE; the idle branch opens the fresh walk
      state_d = ST_LOAD;
      cnt_d   = 3'h1;
      ptr_d   = step_ptr(load_ptr_q, dir_q);
    end
    if (act_start) begin
      arm_d   = 1'b1;                            // [R2]
      state_d = ST_IDLE;
      dir_d   = scan_direction_select;
      ptr_d   = first_ptr(scan_direction_select); // [R6]
      cnt_d   = 3'h0;
    end
  end

  // state registers; ce low freezes everything
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q    <= ST_IDLE;
      dir_q      <= 1'b0;
      load_ptr_q <= `SDL_CH_LEFT;
      cnt_q      <= 3'h0;
      arm_q      <= 1'b0;
    end else if (ce) begin
      state_q    <= state_d;
      dir_q      <= dir_d;
      load_ptr_q <= ptr_d;
      cnt_q      <= cnt_d;
      arm_q      <= arm_d;
    end
  end

  // the start edge itself loads nothing, even if it ends a sequence
  wire                do_write;
  wire [`SDL_NCH-1:0] lat_we;

  assign do_write = wr_en && !act_start;

  // one-hot latch select; pointer codes 6 and 7 select nothing, so a
  // corrupted pointer can never write past the six latches
  function [`SDL_NCH-1:0] chan_sel;
    input [`SDL_PTR_W-1:0] p;
    integer                c;
    begin
      chan_sel = {`SDL_NCH{1'b0}};
      for (c = 0; c < `SDL_NCH; c = c + 1) begin
        if (p == c[`SDL_PTR_W-1:0]) begin
          chan_sel[c] = 1'b1;
        end
      end
    end
  endfunction

  assign lat_we = do_write ? chan_sel(load_ptr_q) : {`SDL_NCH{1'b0}};

  // channel latches take the full code on each loading edge
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (i = 0; i < `SDL_NCH; i = i + 1) begin
        lat_q[i] <= `SDL_CODE_RST;
      end
    end else if (ce) begin
      for (i = 0; i < `SDL_NCH; i = i + 1) begin
        if (lat_we[i]) begin
          lat_q[i] <= act_code;                  // [R1]
        end
      end
    end
  end

  // busy shows a walk in progress, including the armed edge; it is taken
  // from the next-state values so it lines up with the pointer it describes
  wire busy_d;

  assign busy_d = arm_d || (state_d == ST_LOAD);

  // busy register
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_busy_q <= 1'b0;
    end else if (ce) begin
      load_busy_q <= busy_d;
    end
  end

  // transfer strobe is looked at on rising edges whatever the phase select;
  // the move happens one rising edge later. a mid-load transfer moves a
  // partial set, which the controller is expected to avoid
  // registering the strobe keeps its decode off the converter clock path,
  // at the cost of the one-edge delay the transfer timing asks for anyway
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      xfer_pending_q <= 1'b0;
    end else if (ce) begin
      xfer_pending_q <= output_transfer_strobe;  // [R7] [R13]
    end
  end

  // six converter channels, all updated by the same pulse
  // one pulse for all six is what keeps the columns in step; a per-channel
  // enable would let a late channel show the previous line
  genvar g;
  generate
    for (g = 0; g < `SDL_NCH; g = g + 1) begin : g_ch
      sdl_chan_conv u_conv (
        .clk             (clk),
        .rst_n           (rst_n_q),
        .ce              (ce),
        .xfer            (xfer_pending_q),       // [R8]
        .code_in         (lat_q[g]),
        .polarity_invert (polarity_invert),      // [R9]
        .low_power_hold  (low_power_hold),       // [R10]
        .code_q          (channel_outputs[g*`SDL_CODE_W +: `SDL_CODE_W]),
        .away_steps_q    (channel_away_steps[g*`SDL_CODE_W +: `SDL_CODE_W]),
        .above_mid_q     (channel_above_mid[g]),
        .drive_en_q      (channel_drive_en[g])
      );
    end
  endgenerate

endmodule // sdl_loader

`default_nettype wire

// File: verification/sdl_ctl_model.sv
// timing controller model: start, six codes, then transfer strobe
`timescale 1ns/10ps
`default_nettype none
module sdl_ctl_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        rs,
  input  wire logic [59:0] frame,
  output var  logic [9:0]  code,
  output var  logic        start,
  output var  logic        strobe,
  output var  logic        done
);
  integer k;
  // one frame per go; rs adds an aborted walk so the restart path is exercised
  initial begin
    {code, start, strobe, done} = 13'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        #1 done = 1'b0;
        if (rs) begin
          start = 1'b1;
          @(posedge clk);
          #1 start = 1'b0;
          code = ~frame[9:0];
          @(posedge clk);
          #1;
        end
        start = 1'b1;
        for (k = 0; k < 6; k = k + 1) begin
          @(posedge clk);
          #1 start = 1'b0;
          code = frame[10*k +: 10];
        end
        @(posedge clk);
        #1 code = ~code; // idle bus never repeats the last code
        strobe = 1'b1;
        @(posedge clk);
        #1 strobe = 1'b0;
        done = 1'b1;
      end
    end
  end
endmodule // sdl_ctl_model
`default_nettype wire

// File: verification/sdl_loader_monitor.sv
// port assertions for the loader
`timescale 1ns/10ps
`default_nettype none
module sdl_loader_monitor (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ce,
  input wire logic        load_sequence_start,
  input wire logic        scan_direction_select,
  input wire logic        edge_phase_select,
  input wire logic        output_transfer_strobe,
  input wire logic        polarity_invert,
  input wire logic        low_power_hold,
  input wire logic [59:0] channel_outputs,
  input wire logic [59:0] channel_away_steps,
  input wire logic [5:0]  channel_above_mid,
  input wire logic [5:0]  channel_drive_en,
  input wire logic        load_busy_q,
  input wire logic [2:0]  load_ptr_q,
  input wire logic        xfer_pending_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // start seen on a rising active edge
  sequence seq_start;
    ce && edge_phase_select && load_sequence_start;
  endsequence
  // six load edges with no restart
  sequence seq_loads;
    (ce && !load_sequence_start)[*6];
  endsequence
  // pointer set to the end picked by the direction on the start edge
  property p_start_chan;
    seq_start |=> load_ptr_q == ($past(scan_direction_select) ? 3'h5 : 3'h0);
  endproperty
  // drive enable is the registered inverse of the hold input
  property p_hold_debias;
    ce |=> channel_drive_en == {6{!$past(low_power_hold)}};
  endproperty
  chk_xfer_seen: assert property (ce |=> xfer_pending_q == $past(output_transfer_strobe))
    else $error("transfer strobe not registered");
  chk_out_hold: assert property (!xfer_pending_q |=> $stable(channel_outputs))
    else $error("outputs moved without transfer");
  chk_away_code: assert property (channel_away_steps == ~channel_outputs)
    else $error("step count not full scale minus code");
  chk_pol_region: assert property (ce |=> channel_above_mid == {6{$past(polarity_invert)}})
    else $error("region flag wrong");
  chk_hold_debias: assert property (p_hold_debias)
    else $error("drive enable wrong");
  chk_seq_begin: assert property (seq_start |=> load_busy_q)
    else $error("walk did not begin");
  chk_start_chan: assert property (p_start_chan)
    else $error("walk started at wrong channel");
  chk_walk_six: assert property (seq_start ##1 seq_loads |=> !load_busy_q)
    else $error("walk not six loads");
endmodule // sdl_loader_monitor
bind sdl_loader sdl_loader_monitor i_mon (.clk(clk), .arst_n(arst_n), .ce(ce),
  .load_sequence_start(load_sequence_start), .scan_direction_select(scan_direction_select),
  .edge_phase_select(edge_phase_select), .output_transfer_strobe(output_transfer_strobe),
  .polarity_invert(polarity_invert), .low_power_hold(low_power_hold),
  .channel_outputs(channel_outputs), .channel_away_steps(channel_away_steps),
  .channel_above_mid(channel_above_mid), .channel_drive_en(channel_drive_en),
  .load_busy_q(load_busy_q), .load_ptr_q(load_ptr_q), .xfer_pending_q(xfer_pending_q));
`default_nettype wire

// File: verification/six_channel_decimating_loader_tb.sv
// testbench: frames in every edge and direction mode
`timescale 1ns/10ps
`default_nettype none
module six_channel_decimating_loader_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        dir = 1'b0;
  logic        eps = 1'b1;
  logic        pol = 1'b0;
  logic        hold = 1'b1;
  logic        go = 1'b0;
  logic        rs = 1'b0;
  logic [59:0] frame = 60'h0;
  logic [63:0] rnd;
  logic [9:0]  code;
  logic        start, strobe, done;
  wire  [59:0] outs, away;
  wire  [5:0]  above, drv;
  integer      mismatches = 0, check_count = 0, seed = 11, i, n;
  always #5 clk = ~clk;
  sdl_ctl_model i_ctl (.clk(clk), .go(go), .rs(rs), .frame(frame), .code(code),
    .start(start), .strobe(strobe), .done(done));
  sdl_loader i_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .pixel_code_in(code),
    .load_sequence_start(start), .scan_direction_select(dir), .edge_phase_select(eps),
    .output_transfer_strobe(strobe), .polarity_invert(pol), .low_power_hold(hold),
    .channel_outputs(outs), .channel_away_steps(away), .channel_above_mid(above),
    .channel_drive_en(drv), .load_busy_q(), .load_ptr_q(), .xfer_pending_q());
  // channel order after a walk in the given direction
  function automatic [59:0] exp_out(input [59:0] f, input d);
    integer k;
    exp_out = f;
    if (d) for (k = 0; k < 6; k = k + 1) exp_out[10*k +: 10] = f[10*(5-k) +: 10];
  endfunction
  // steps away from the reference level: full-scale code minus each code
  function automatic [59:0] exp_away(input [59:0] c);
    integer k;
    for (k = 0; k < 6; k = k + 1) exp_away[10*k +: 10] = 10'h3FF - c[10*k +: 10];
  endfunction
  task automatic cmp(input [59:0] got, input [59:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hold stays high through reset so drive enable matches the reset value
  initial begin
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    cmp(outs, 60'h0);
    cmp(away, {6{10'h3FF}});
    for (i = 0; i < 12; i = i + 1) begin
      @(posedge clk);
      #1 rnd = {$random(seed), $random(seed)};
      frame = rnd[59:0];
      if (i < 2) frame = {6{i[0] ? 10'h3FF : 10'h000}}; // full-scale corners
      {hold, rs, eps, dir} = i[3:0] ^ 4'h2;
      pol = rnd[63];
      go = 1'b1;
      @(posedge clk);
      #1 go = 1'b0;
      @(posedge clk);
      for (n = 0; n < 40 && done !== 1'b1; n = n + 1) @(posedge clk);
      if (n == 40) begin
        mismatches = mismatches + 1;
        i = 12; // timed out: leave the loop for the closing report
      end else begin
        #2 cmp(outs, exp_out(frame, dir));
        cmp(away, exp_away(exp_out(frame, dir)));
        cmp({54'h0, above}, {54'h0, {6{pol}}});
        cmp({54'h0, drv}, {54'h0, {6{~hold}}});
      end
    end
    // ce low freezes the registered flags while their inputs move
    @(posedge clk);
    #1 ce = 1'b0;
    pol = ~pol;
    hold = ~hold;
    repeat (3) @(posedge clk);
    #2 cmp({54'h0, above}, {54'h0, {6{~pol}}});
    cmp({54'h0, drv}, {54'h0, {6{hold}}});
    @(posedge clk);
    #1 ce = 1'b1;
    @(posedge clk);
    #2 cmp({54'h0, above}, {54'h0, {6{pol}}});
    cmp({54'h0, drv}, {54'h0, {6{~hold}}});
    wrap_up;
  end
endmodule // six_channel_decimating_loader_tb
`default_nettype wire
